// ===== design/wdo_map.vh
`ifndef WDO_MAP_VH
`define WDO_MAP_VH
// register word indices (printed offsets are not all multiples of four,
// so the printed value is an index and the byte address is four times it)
`define WDO_IDX_PERIOD_WINDOW   16'hFFDB
`define WDO_IDX_POWER_UP        16'hFFFF
`define WDO_IDX_REFRESH         16'h0100
`define WDO_IDX_START           16'h0101
`define WDO_IDX_CONTROL         16'h0102
`define WDO_IDX_STATUS          16'h0103
`define WDO_IDX_ERASE           16'h0104
`define WDO_ADDR_W              18
// option reset (erased) value
`define WDO_OPT_ERASED          8'hFF
// power-up option field positions
`define WDO_PU_AUTOSTART_DIS    0
`define WDO_PU_CODE_PROT_DIS    2
`define WDO_PU_CODE_PROT_SEL    3
`define WDO_PU_LEVEL_LO         4
`define WDO_PU_LEVEL_HI         5
`define WDO_PU_DETECT_START     6
`define WDO_PU_SRC_PROT_INIT    7
// period/window option field positions
`define WDO_PW_PERIOD_LO        0
`define WDO_PW_PERIOD_HI        1
`define WDO_PW_WINDOW_LO        2
`define WDO_PW_WINDOW_HI        3
// initial counts
`define WDO_CNT_P0              14'h03FF
`define WDO_CNT_P1              14'h0FFF
`define WDO_CNT_P2              14'h1FFF
`define WDO_CNT_P3              14'h3FFF
// refresh key bytes
`define WDO_KEY_FIRST           8'h00
`define WDO_KEY_SECOND          8'hFF
// control register bit positions
`define WDO_CTL_RESET_SEL       0
// erase command bits
`define WDO_ERASE_POWER_UP      0
`define WDO_ERASE_PERIOD_WIN    1
// prescaler ratio
`define WDO_PRESCALE            16
// axi responses
`define WDO_RESP_OKAY           2'h0
`define WDO_RESP_SLVERR         2'h2
`endif

// ===== design/wdo_window_judge.v
`include "wdo_map.vh"

// judges a refresh against the acknowledgement window
module wdo_window_judge #(
  parameter CNT_W = 14
) (
  input  wire [CNT_W-1:0] countVal,   // current down count
  input  wire [CNT_W-1:0] initVal,    // configured initial count
  input  wire [1:0]       windowSel,  // window field
  output reg              inWindow    // high while a refresh is accepted
);

  reg [CNT_W+1:0] limit;

  ////////////////////////////////////////////////////////////////////////
  // the window is the last part of the period before underflow, so the
  // remaining count must be at or below the chosen fraction of the start
  always @*
  begin
    limit = {2'b00, initVal};
    case (windowSel)
      2'b00: limit = {2'b00, initVal} >> 2;
      2'b01: limit = {2'b00, initVal} >> 1;
      2'b10: limit = ({2'b00, initVal} + {1'b0, initVal, 1'b0}) >> 2;
      default: limit = {2'b00, initVal};
    endcase
    inWindow = ({2'b00, countVal} <= limit);
  end

endmodule

// ===== design/wdo_watchdog_option.v
`include "wdo_map.vh"

module wdo_watchdog_option #(
  parameter CNT_W    = 14,
  parameter PRESCALE = `WDO_PRESCALE
) (
  input  wire        core_clk,         // system clock, 10 MHz
  input  wire        rst,              // synchronous reset, active high
  input  wire [17:0] s_axi_awaddr,     // write address
  input  wire        s_axi_awvalid,    // write address valid
  output wire        s_axi_awready,    // write address ready
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire        s_axi_wvalid,     // write data valid
  output wire        s_axi_wready,     // write data ready
  output reg  [1:0]  s_axi_bresp,      // write response
  output reg         s_axi_bvalid,     // write response valid
  input  wire        s_axi_bready,     // write response ready
  input  wire [17:0] s_axi_araddr,     // read address
  input  wire        s_axi_arvalid,    // read address valid
  output wire        s_axi_arready,    // read address ready
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read response
  output reg         s_axi_rvalid,     // read data valid
  input  wire        s_axi_rready,     // read data ready
  output reg         srcProtectEn,     // count source protection after reset
  output reg         codeProtectEn,    // rom code protection active
  output reg  [1:0]  detectLevel,      // threshold code, 0=3.80V..3=1.90V
  output reg         monitorResetEn,   // voltage monitor 0 reset enabled
  output reg         powerOnResetEn,   // power-on reset uses same level
  output reg         wdtIrq,           // one-cycle watchdog interrupt
  output reg         wdtReset          // one-cycle watchdog reset request
);

  // flash-held bytes start erased and survive rst, so that what software
  // programmed is what the next reset decodes; only an erase clears them
  reg  [7:0]       powerUp_ff   = `WDO_OPT_ERASED; // power-up option
  reg  [7:0]       periodWin_ff = `WDO_OPT_ERASED; // period/window option
  reg              puWritten_ff = 1'b0;            // one-time-program guards
  reg              pwWritten_ff = 1'b0;
  reg              resetSel_ff;
  reg              running_ff;
  reg              keyArmed_ff;
  reg              badWrite_ff;     // sticky incorrect-write seen
  reg              underflow_ff;    // sticky underflow seen
  reg  [CNT_W-1:0] count_ff;
  reg  [7:0]       presc_ff;
  reg              optLoad_ff;      // options sampled after reset release
  reg  [17:0]      awAddr_ff;
  reg  [31:0]      wData_ff;
  reg  [3:0]       wStrb_ff;
  reg              awHave_ff;
  reg              wHave_ff;
  reg  [CNT_W-1:0] initVal;
  wire             inWindow;
  wire             doWrite;
  wire             tick;
  wire [15:0]      wIdx;
  wire [15:0]      rIdx;
  reg              wrRefresh;
  reg              refreshOk;
  reg              refreshBad;
  reg              uflow;

  ////////////////////////////////////////////////////////////////////////
  // write channels are taken independently and held until both arrive
  assign s_axi_awready = ~awHave_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHave_ff & wHave_ff & ~s_axi_bvalid;
  assign wIdx          = awAddr_ff[17:2];
  assign rIdx          = s_axi_araddr[17:2];

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      awHave_ff <= 1'b0;
      wHave_ff  <= 1'b0;
      awAddr_ff <= 18'h00000;
      wData_ff  <= 32'h00000000;
      wStrb_ff  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      else if (doWrite)
        awHave_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      else if (doWrite)
        wHave_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write decode and response; only the low byte lane carries data
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WDO_RESP_OKAY;
      // option bytes are left alone here: clearing them would lose the
      // program before the decode that follows reset could see it
      resetSel_ff  <= 1'b0;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `WDO_RESP_OKAY;
        if (wIdx == `WDO_IDX_POWER_UP)
        begin
          if (wStrb_ff[0] && !puWritten_ff)
          begin
            powerUp_ff   <= wData_ff[7:0];
            puWritten_ff <= 1'b1;
          end
        end
        else if (wIdx == `WDO_IDX_PERIOD_WINDOW)
        begin
          if (wStrb_ff[0] && !pwWritten_ff)
          begin
            periodWin_ff <= wData_ff[7:0];
            pwWritten_ff <= 1'b1;
          end
        end
        else if (wIdx == `WDO_IDX_CONTROL)
        begin
          // reset select can only be set, never cleared by software
          if (wStrb_ff[0] && wData_ff[`WDO_CTL_RESET_SEL])
            resetSel_ff <= 1'b1;
        end
        else if (wIdx == `WDO_IDX_ERASE)
        begin
          if (wStrb_ff[0] && wData_ff[`WDO_ERASE_POWER_UP])
          begin
            powerUp_ff   <= `WDO_OPT_ERASED;
            puWritten_ff <= 1'b0;
          end
          if (wStrb_ff[0] && wData_ff[`WDO_ERASE_PERIOD_WIN])
          begin
            periodWin_ff <= `WDO_OPT_ERASED;
            pwWritten_ff <= 1'b0;
          end
        end
        else if (wIdx != `WDO_IDX_REFRESH && wIdx != `WDO_IDX_START)
          s_axi_bresp <= `WDO_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path answers one cycle after the address is taken
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `WDO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `WDO_RESP_OKAY;
        if (rIdx == `WDO_IDX_POWER_UP)
          s_axi_rdata <= {24'h000000, powerUp_ff};
        else if (rIdx == `WDO_IDX_PERIOD_WINDOW)
          s_axi_rdata <= {24'h000000, periodWin_ff};
        else if (rIdx == `WDO_IDX_CONTROL)
          s_axi_rdata <= {31'h00000000, resetSel_ff};
        else if (rIdx == `WDO_IDX_STATUS)
          s_axi_rdata <= {4'h0, underflow_ff, badWrite_ff, keyArmed_ff,
                          running_ff, {(24-CNT_W){1'b0}}, count_ff};
        else if (rIdx == `WDO_IDX_REFRESH || rIdx == `WDO_IDX_START ||
                 rIdx == `WDO_IDX_ERASE)
          s_axi_rdata <= 32'h00000000;
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `WDO_RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up option decode, refreshed one cycle after reset release; the period and window decode is combinational and always live
  // period field to initial count
  always @*
  begin
    case ({periodWin_ff[`WDO_PW_PERIOD_HI], periodWin_ff[`WDO_PW_PERIOD_LO]})
      2'b00:   initVal = `WDO_CNT_P0;
      2'b01:   initVal = `WDO_CNT_P1;
      2'b10:   initVal = `WDO_CNT_P2;
      default: initVal = `WDO_CNT_P3;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      optLoad_ff     <= 1'b1;
      srcProtectEn   <= 1'b0;
      codeProtectEn  <= 1'b0;
      detectLevel    <= 2'b00;
      monitorResetEn <= 1'b0;
      powerOnResetEn <= 1'b0;
    end
    else if (optLoad_ff)
    begin
      // settings are caught once, after reset, as the device boots
      optLoad_ff     <= 1'b0;
      srcProtectEn   <= ~powerUp_ff[`WDO_PU_SRC_PROT_INIT];
      codeProtectEn  <= powerUp_ff[`WDO_PU_CODE_PROT_DIS] &
                        ~powerUp_ff[`WDO_PU_CODE_PROT_SEL];
      detectLevel    <= {powerUp_ff[`WDO_PU_LEVEL_HI],
                         powerUp_ff[`WDO_PU_LEVEL_LO]};
      monitorResetEn <= ~powerUp_ff[`WDO_PU_DETECT_START];
      // power-on reset shares the level and enable
      powerOnResetEn <= ~powerUp_ff[`WDO_PU_DETECT_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler tick; counting only, the count source itself is abstract
  assign tick = running_ff && (presc_ff == PRESCALE - 1);

  wdo_window_judge #(
    .CNT_W     (CNT_W)
  ) u_judge (
    .countVal  (count_ff),
    .initVal   (initVal),
    .windowSel ({periodWin_ff[`WDO_PW_WINDOW_HI],
                 periodWin_ff[`WDO_PW_WINDOW_LO]}),
    .inWindow  (inWindow)
  );

  // refresh key decode
  always @*
  begin
    wrRefresh  = doWrite && (wIdx == `WDO_IDX_REFRESH) && wStrb_ff[0];
    refreshOk  = wrRefresh && running_ff && keyArmed_ff &&
                 (wData_ff[7:0] == `WDO_KEY_SECOND) && inWindow;
    refreshBad = wrRefresh && running_ff && keyArmed_ff &&
                 (wData_ff[7:0] == `WDO_KEY_SECOND) && !inWindow;
    uflow      = tick && (count_ff == {CNT_W{1'b0}});
  end

  ////////////////////////////////////////////////////////////////////////
  // down counter, start control and fault reporting
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      running_ff   <= 1'b0;
      optLoad2Run;
    end
    else
    begin
      if (optLoad_ff)
        // auto start when bit is zero
        running_ff <= ~powerUp_ff[`WDO_PU_AUTOSTART_DIS];
      else if (doWrite && wIdx == `WDO_IDX_START)
        running_ff <= 1'b1;
      if (running_ff)
        presc_ff <= tick ? 8'h00 : presc_ff + 8'h01;
      if (wrRefresh && running_ff)
        keyArmed_ff <= (wData_ff[7:0] == `WDO_KEY_FIRST);
      if (optLoad_ff || refreshOk || refreshBad || uflow)
        count_ff <= initVal;
      else if (tick)
        count_ff <= count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      // sticky flags; set wins, cleared only by reset
      if (refreshBad)
        badWrite_ff <= 1'b1;
      if (uflow)
        underflow_ff <= 1'b1;
      wdtIrq   <= (refreshBad | uflow) & ~resetSel_ff;
      wdtReset <= (refreshBad | uflow) & resetSel_ff;
    end
  end

  task optLoad2Run;
  begin
    presc_ff     <= 8'h00;
    keyArmed_ff  <= 1'b0;
    badWrite_ff  <= 1'b0;
    underflow_ff <= 1'b0;
    count_ff     <= `WDO_CNT_P3;
    wdtIrq       <= 1'b0;
    wdtReset     <= 1'b0;
  end
  endtask

endmodule

// ===== test/wdo_props.sv
module wdo_props (
  input wire        core_clk,        // clock
  input wire        rst,             // sync reset
  input wire        s_axi_awvalid,   // aw valid
  input wire        s_axi_awready,   // aw ready
  input wire        s_axi_wvalid,    // w valid
  input wire        s_axi_wready,    // w ready
  input wire [1:0]  s_axi_bresp,     // b response
  input wire        s_axi_bvalid,    // b valid
  input wire        s_axi_bready,    // b ready
  input wire        s_axi_arvalid,   // ar valid
  input wire        s_axi_arready,   // ar ready
  input wire [31:0] s_axi_rdata,     // read data
  input wire        s_axi_rvalid,    // r valid
  input wire        s_axi_rready,    // r ready
  input wire        monitorResetEn,  // monitor reset enable
  input wire        powerOnResetEn,  // power-on reset enable
  input wire        wdtIrq,          // interrupt pulse
  input wire        wdtReset         // reset pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes: answers come within two cycles and are held until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_soon;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_soon: assert property (p_b_soon) else $error("write response late");
  property p_r_next;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  // a second request must not slip in under an open answer
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken early");
  ////////////////////////////////////////////////////////////////////////////
  // watchdog events are single pulses on one of two outputs, quiet after reset; both resets share one enable
  property p_irq_one;
    wdtIrq |=> !wdtIrq;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq too long");
  property p_rst_one;
    $rose(wdtReset) |=> $fell(wdtReset);
  endproperty
  a_rst_one: assert property (p_rst_one) else $error("reset long");
  property p_excl;
    !(wdtIrq && wdtReset);
  endproperty
  a_excl: assert property (p_excl) else $error("both events");
  property p_quiet;
    $fell(rst) |-> (!wdtIrq && !wdtReset) [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("event after reset");
  property p_level_same;
    monitorResetEn == powerOnResetEn;
  endproperty
  a_level_same: assert property (p_level_same) else $error("split");
endmodule

// ===== test/wdo_tb.sv
`include "wdo_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0, ad;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'h52B8701A, rd, v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, srcProtectEn, codeProtectEn, monitorResetEn;
  wire         powerOnResetEn, wdtIrq, wdtReset;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, detectLevel;
  wire  [31:0] s_axi_rdata;
  logic [1:0]  rsp;
  int          bad_count = 0, checked = 0, cyc = 0;
  int          irqCnt = 0, n0 = 0, m = 0;
  localparam logic [17:0] A_PW = {`WDO_IDX_PERIOD_WINDOW, 2'b00};
  localparam logic [17:0] A_PU = {`WDO_IDX_POWER_UP, 2'b00};
  localparam logic [17:0] A_REF = {`WDO_IDX_REFRESH, 2'b00};
  localparam logic [17:0] A_GO = {`WDO_IDX_START, 2'b00};
  localparam logic [17:0] A_CTL = {`WDO_IDX_CONTROL, 2'b00};
  localparam logic [17:0] A_ST = {`WDO_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_ER = {`WDO_IDX_ERASE, 2'b00};

  // short prescale keeps two full underflow periods inside the run
  wdo_watchdog_option #(.PRESCALE(1)) dut_u (.*);

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    // interrupt pulses are counted so a check never races the pulse
    if (wdtIrq)
      irqCnt <= irqCnt + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // tail window limit, floor of the fraction
  function automatic logic [13:0] lim(input logic [13:0] n, input int s);
    return 14'((n * (s + 1)) / 4);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    bit aw, w;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [17:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic final_report();
    $display("mismatches %0d of %0d compares", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // erased options decode to the all-ones settings
    rdr(A_ST);
    chk(rd[24], 0);
    chk(rd[13:0], 14'h3FFF);
    chk(srcProtectEn, 0);
    chk(codeProtectEn, 0);
    chk(detectLevel, 2'h3);
    chk(monitorResetEn, 0);
    rdr(18'h0);
    chk(rsp, `WDO_RESP_SLVERR);
    wr(18'h0, 32'h0);
    chk(rsp, `WDO_RESP_SLVERR);
    // program once per erase, read back, erase restores all ones
    for (int i = 0; i < 2; i++)
    begin
      ad = i ? A_PW : A_PU;
      rdr(ad);
      chk(rd, 32'hFF);
      v = xs();
      wr(ad, v);
      rdr(ad);
      chk(rd, {24'h0, v[7:0]});
      wr(A_ER, i ? 32'h2 : 32'h1);
      rdr(ad);
      chk(rd, 32'hFF);
    end
    // no refresh is issued before the start write
    wr(A_GO, xs());
    rdr(A_ST);
    chk(rd[24], 1);
    wr(A_REF, 32'h0);
    rdr(A_ST);
    chk(rd[25], 1);
    v = xs();
    wr(A_REF, {24'h0, v[7:2], 2'b01});
    rdr(A_ST);
    chk(rd[25], 0);
    repeat (300) @(posedge core_clk);
    wr(A_REF, 32'h0);
    wr(A_REF, 32'hFF);
    rdr(A_ST);
    chk(rd[13:0] > 14'h3FD0, 1);
    chk(rd[26], 0);
    // first underflow interrupts, second resets after select is set
    for (int i = 0; i < 2; i++)
    begin
      while (!(wdtIrq || wdtReset)) @(posedge core_clk);
      chk(wdtIrq, i == 0);
      chk(wdtReset, i == 1);
      wr(A_CTL, 32'h1);
    end
    rdr(A_ST);
    chk(rd[27], 1);
    // each window: program options, pulse reset, then refresh early,
    // 16 counts above the limit (skipped for the full window) and 16 counts below it
    for (int s = 0; s < 4; s++)
    begin
      wr(A_ER, 32'h3);
      v = xs() & 32'h000000FE;
      wr(A_PU, v);
      wr(A_PW, {28'hFFFFFFF, s[1:0], 2'b00});
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(srcProtectEn, !v[7]);
      chk(codeProtectEn, v[2] && !v[3]);
      chk(detectLevel, v[5:4]);
      chk(monitorResetEn, !v[6]);
      chk(powerOnResetEn, !v[6]);
      for (int k = 0; k < 3; k++)
      begin
        if (s == 3 && k == 1)
          continue;
        // the key byte lands m + 8 counts after the last reload
        m = `WDO_CNT_P0 - lim(`WDO_CNT_P0, s) - 8 + (k == 1 ? -16 : 16);
        wr(A_REF, 32'h0);
        if (k > 0)
          repeat (m) @(posedge core_clk);
        n0 = irqCnt;
        wr(A_REF, 32'hFF);
        @(posedge core_clk);
        chk(irqCnt - n0, !(k == 2 || s == 3));
      end
      rdr(A_ST);
      chk(rd[26], s < 3);
      chk(rd[24], 1);
      chk(rd[13:0] > 14'h03E0 && rd[13:0] <= `WDO_CNT_P0, 1);
    end
    final_report;
  end
endmodule

bind wdo_watchdog_option wdo_props props_u (
  .core_clk       (core_clk),
  .rst            (rst),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_bresp    (s_axi_bresp),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rdata    (s_axi_rdata),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .monitorResetEn (monitorResetEn),
  .powerOnResetEn (powerOnResetEn),
  .wdtIrq         (wdtIrq),
  .wdtReset       (wdtReset)
);
